//--- hw/mic_regs.svh
// register map, field positions, reset values and fixed sizes of the interrupt controller
`ifndef MIC_REGS_SVH
`define MIC_REGS_SVH

// byte addresses on the APB
`define MIC_ADDR_EDGE_SEL 8'h00
`define MIC_ADDR_CTRL_PRI 8'h04
`define MIC_ADDR_CTRL_SEC 8'h08
`define MIC_ADDR_STATUS 8'h0c

// ext_edge_select fields and codes
`define MIC_EDGE_SEL_LSB 0
`define MIC_EDGE_OFF 2'b00
`define MIC_EDGE_RISE 2'b01
`define MIC_EDGE_FALL 2'b10
`define MIC_EDGE_BOTH 2'b11

// irq_control_primary fields
`define MIC_PRI_GLOBAL_EN 0
`define MIC_PRI_PIN_EN 1
`define MIC_PRI_TB_EN 2
`define MIC_PRI_T0_EN 3
`define MIC_PRI_PIN_F 4
`define MIC_PRI_TB_F 5
`define MIC_PRI_T0_F 6

// irq_control_second fields
`define MIC_SEC_T1_EN 0
`define MIC_SEC_CONV_EN 1
`define MIC_SEC_T1_F 4
`define MIC_SEC_CONV_F 5

// status fields
`define MIC_STAT_PIN 0
`define MIC_STAT_FULL 1
`define MIC_STAT_SP_LSB 4

// reset values
`define MIC_RST_EDGE_SEL 2'b00
`define MIC_RST_FLAGS 5'h00
`define MIC_RST_ENABLES 5'h00
`define MIC_RST_GLOBAL_EN 1'b0

// source indices, index 0 is the highest priority
`define MIC_SRC_PIN 0
`define MIC_SRC_T0 1
`define MIC_SRC_TB 2
`define MIC_SRC_T1 3
`define MIC_SRC_CONV 4
`define MIC_NSRC 5

// program counter and call stack sizes
`define MIC_PC_W 12
`define MIC_STACK_DEPTH 4'h8
`define MIC_STACK_AW 3
`define MIC_SP_W 4

// vector addresses
`define MIC_VEC_PIN 12'h004
`define MIC_VEC_T0 12'h008
`define MIC_VEC_TB 12'h00c
`define MIC_VEC_T1 12'h010
`define MIC_VEC_CONV 12'h014

`endif

//--- hw/mic_pkg.sv
// types shared by the interrupt controller files
`default_nettype none
`include "mic_regs.svh"
package mic_pkg;
  typedef logic [`MIC_PC_W-1:0] mic_pc_t;
  typedef logic [`MIC_NSRC-1:0] mic_src_t;
  typedef logic [`MIC_SP_W-1:0] mic_sp_t;
  typedef logic [`MIC_STACK_AW-1:0] mic_saddr_t;
endpackage : mic_pkg
`default_nettype wire

//--- hw/mic_pin_edge.sv
// synchroniser and selectable edge detector for the external request pin
`default_nettype none
`include "mic_regs.svh"
module mic_pin_edge
  import mic_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic pinAsync,
  input wire logic [1:0] edgeSel,
  output logic pinLevel,
  output logic edgeHit
);
  logic sync1_reg;
  logic sync2_reg;
  logic prev_reg;
  logic edgeHit_next;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      prev_reg <= 1'b0;
    end else begin
      sync1_reg <= pinAsync;
      sync2_reg <= sync1_reg;
      prev_reg <= sync2_reg;
    end
  end

  // bit 0 selects rising, bit 1 falling; 00 leaves both off
  assign edgeHit_next = (edgeSel[0] & sync2_reg & ~prev_reg) | (edgeSel[1] & ~sync2_reg & prev_reg);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      edgeHit <= 1'b0;
      pinLevel <= 1'b0;
    end else begin
      edgeHit <= edgeHit_next;
      pinLevel <= sync2_reg;
    end
  end
endmodule : mic_pin_edge
`default_nettype wire

//--- hw/mic_stack_mem.sv
// call stack storage with registered read data
`default_nettype none
`include "mic_regs.svh"
module mic_stack_mem
  import mic_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic wrEn,
  input wire mic_saddr_t wrAddr,
  input wire mic_pc_t wrData,
  input wire logic rdEn,
  input wire mic_saddr_t rdAddr,
  output mic_pc_t rdData
);
  mic_pc_t mem [0:(1 << `MIC_STACK_AW)-1];

  always_ff @(posedge clk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdData <= '0;
    end else if (rdEn) begin
      rdData <= mem[rdAddr];
    end
  end
endmodule : mic_stack_mem
`default_nettype wire

//--- hw/mic_irq_controller.sv
// vectored interrupt controller with APB registers, call stack and wake-up
//
// Overview of operation
// - edge select off, rise, fall or both
// - selected pin edge sets the pin flag
// - source events set flags regardless of enables
// - jump only when the source enable is high
// - global enable low blocks all vectoring
// - each source has its own vector
// - accept pushes next pc, loads vector
// - return pops saved pc to resume
// - servicing clears the global enable
// - flags still set while vectoring blocked
// - full stack blocks acknowledge until popped
// - simultaneous requests served in fixed priority
// - a flag being set wakes device
// - pin level stays readable while used
// - primary register layout of enables and flags
// - second register holds timer-1 enable, flag
// - converter variant adds converter flag, enable
// - unimplemented bits zero, flags clear at reset
// - servicing clears that source's flag
// - wake-up on any flag rising, enables ignored
//
// Chosen here: the APB register port and the placing of the registers.
`default_nettype none
`include "mic_regs.svh"
module mic_irq_controller
  import mic_pkg::*;
#(
  parameter bit HAS_CONV = 1'b1
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic intPin,
  input wire logic timer0Evt,
  input wire logic timebaseEvt,
  input wire logic timer1Evt,
  input wire logic convEvt,
  input wire logic cpuIrqWindow,
  input wire mic_pc_t cpuPc,
  input wire logic cpuPush,
  input wire logic cpuPop,
  input wire logic cpuPopIsReti,
  output logic irqTake,
  output mic_pc_t vectorAddr,
  output logic retValid,
  output mic_pc_t retPc,
  output logic stackFull,
  output logic pinLevel,
  output logic wakeReq
);
  ////////////////////////////////////////////////////////////////////////////////
  // declarations
  localparam mic_src_t IMPL_MASK = {HAS_CONV, 4'hf};
  localparam mic_pc_t VEC_TABLE [`MIC_NSRC] = '{`MIC_VEC_PIN, `MIC_VEC_T0, `MIC_VEC_TB, `MIC_VEC_T1, `MIC_VEC_CONV};

  logic [1:0] edgeSel_reg;
  logic globalEn_reg;
  mic_src_t srcEn_reg;
  mic_src_t srcFlag_reg;
  mic_src_t srcFlag_next;
  mic_sp_t sp_reg;
  logic pinEdge;
  mic_src_t evtVec;
  mic_src_t pending;
  mic_src_t winner;
  mic_pc_t winVector;
  logic takeNow;
  logic pushNow;
  logic popNow;
  logic apbWrite;
  logic apbSetup;
  logic wrEdge;
  logic wrPri;
  logic wrSec;
  logic addrMapped;
  logic [7:0] priView;
  logic [7:0] secView;
  logic [7:0] statView;
  mic_sp_t spMinus1;

  ////////////////////////////////////////////////////////////////////////////////
  // external pin
  // edge select decoding
  mic_pin_edge u_pin_edge (
    .clk(clk),
    .resetn(resetn),
    .pinAsync(intPin),
    .edgeSel(edgeSel_reg),
    .pinLevel(pinLevel),
    .edgeHit(pinEdge)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // apb decode
  assign pready = 1'b1;
  assign apbWrite = psel & penable & pwrite;
  assign apbSetup = psel & ~penable;
  assign addrMapped = (paddr == `MIC_ADDR_EDGE_SEL) || (paddr == `MIC_ADDR_CTRL_PRI) ||
                      (paddr == `MIC_ADDR_CTRL_SEC) || (paddr == `MIC_ADDR_STATUS);
  assign pslverr = psel & penable & ~addrMapped;
  assign wrEdge = apbWrite & (paddr == `MIC_ADDR_EDGE_SEL);
  assign wrPri = apbWrite & (paddr == `MIC_ADDR_CTRL_PRI);
  assign wrSec = apbWrite & (paddr == `MIC_ADDR_CTRL_SEC);

  always_comb begin
    priView = 8'h00;
    priView[`MIC_PRI_GLOBAL_EN] = globalEn_reg;
    priView[`MIC_PRI_PIN_EN] = srcEn_reg[`MIC_SRC_PIN];
    priView[`MIC_PRI_TB_EN] = srcEn_reg[`MIC_SRC_TB];
    priView[`MIC_PRI_T0_EN] = srcEn_reg[`MIC_SRC_T0];
    priView[`MIC_PRI_PIN_F] = srcFlag_reg[`MIC_SRC_PIN];
    priView[`MIC_PRI_TB_F] = srcFlag_reg[`MIC_SRC_TB];
    priView[`MIC_PRI_T0_F] = srcFlag_reg[`MIC_SRC_T0];
  end

  // converter bits on that variant only
  always_comb begin
    secView = 8'h00;
    secView[`MIC_SEC_T1_EN] = srcEn_reg[`MIC_SRC_T1];
    secView[`MIC_SEC_T1_F] = srcFlag_reg[`MIC_SRC_T1];
    secView[`MIC_SEC_CONV_EN] = srcEn_reg[`MIC_SRC_CONV] & HAS_CONV;
    secView[`MIC_SEC_CONV_F] = srcFlag_reg[`MIC_SRC_CONV] & HAS_CONV;
  end

  always_comb begin
    statView = 8'h00;
    statView[`MIC_STAT_PIN] = pinLevel;
    statView[`MIC_STAT_FULL] = stackFull;
    statView[`MIC_STAT_SP_LSB +: `MIC_SP_W] = sp_reg;
  end

  // data is captured in the setup cycle so the access phase needs no wait state
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      prdata <= 32'h0000_0000;
    end else if (apbSetup && !pwrite) begin
      unique case (paddr)
        `MIC_ADDR_EDGE_SEL: prdata <= {30'h0, edgeSel_reg};
        `MIC_ADDR_CTRL_PRI: prdata <= {24'h00_0000, priView};
        `MIC_ADDR_CTRL_SEC: prdata <= {24'h00_0000, secView};
        `MIC_ADDR_STATUS: prdata <= {24'h00_0000, statView};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // configuration registers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      edgeSel_reg <= `MIC_RST_EDGE_SEL;
    end else if (wrEdge) begin
      edgeSel_reg <= pwdata[`MIC_EDGE_SEL_LSB +: 2];
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      srcEn_reg <= `MIC_RST_ENABLES;
    end else begin
      if (wrPri) begin
        srcEn_reg[`MIC_SRC_PIN] <= pwdata[`MIC_PRI_PIN_EN];
        srcEn_reg[`MIC_SRC_TB] <= pwdata[`MIC_PRI_TB_EN];
        srcEn_reg[`MIC_SRC_T0] <= pwdata[`MIC_PRI_T0_EN];
      end
      if (wrSec) begin
        srcEn_reg[`MIC_SRC_T1] <= pwdata[`MIC_SEC_T1_EN];
        srcEn_reg[`MIC_SRC_CONV] <= pwdata[`MIC_SEC_CONV_EN] & HAS_CONV;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // arbitration
  // raw events, enables not consulted
  assign evtVec = {convEvt & HAS_CONV, timer1Evt, timebaseEvt, timer0Evt, pinEdge};

  assign pending = srcFlag_reg & srcEn_reg & IMPL_MASK;

  assign winner = pending & (~pending + 5'h01);

  always_comb begin
    winVector = '0;
    for (int i = 0; i < `MIC_NSRC; i++) begin
      if (winner[i]) begin
        winVector = winVector | VEC_TABLE[i];
      end
    end
  end

  assign takeNow = cpuIrqWindow & globalEn_reg & (|pending) & ~stackFull & ~cpuPush & ~cpuPop;

  ////////////////////////////////////////////////////////////////////////////////
  // request flags
  // software writes land directly
  // serviced flag cleared, new event wins
  always_comb begin
    srcFlag_next = srcFlag_reg;
    if (wrPri) begin
      srcFlag_next[`MIC_SRC_PIN] = pwdata[`MIC_PRI_PIN_F];
      srcFlag_next[`MIC_SRC_TB] = pwdata[`MIC_PRI_TB_F];
      srcFlag_next[`MIC_SRC_T0] = pwdata[`MIC_PRI_T0_F];
    end
    if (wrSec) begin
      srcFlag_next[`MIC_SRC_T1] = pwdata[`MIC_SEC_T1_F];
      srcFlag_next[`MIC_SRC_CONV] = pwdata[`MIC_SEC_CONV_F];
    end
    if (takeNow) begin
      srcFlag_next = srcFlag_next & ~winner;
    end
    srcFlag_next = (srcFlag_next | evtVec) & IMPL_MASK;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      srcFlag_reg <= `MIC_RST_FLAGS;
    end else begin
      srcFlag_reg <= srcFlag_next;
    end
  end

  // wake on a flag being set
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wakeReq <= 1'b0;
    end else begin
      wakeReq <= |(srcFlag_next & ~srcFlag_reg);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // global enable
  // cleared on service, set by a return that is a reti
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      globalEn_reg <= `MIC_RST_GLOBAL_EN;
    end else begin
      if (wrPri) begin
        globalEn_reg <= pwdata[`MIC_PRI_GLOBAL_EN];
      end
      if (takeNow) begin
        globalEn_reg <= 1'b0;
      end
      if (popNow && cpuPopIsReti) begin
        globalEn_reg <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // call stack
  // a pop in the same cycle as a call push wins; the core never issues both
  assign stackFull = (sp_reg == `MIC_STACK_DEPTH);
  assign popNow = cpuPop & (sp_reg != '0);
  assign pushNow = takeNow | (cpuPush & ~cpuPop & ~stackFull);
  assign spMinus1 = sp_reg - 4'h1;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sp_reg <= '0;
    end else if (popNow) begin
      sp_reg <= spMinus1;
    end else if (pushNow) begin
      sp_reg <= sp_reg + 4'h1;
    end
  end

  mic_stack_mem u_stack_mem (
    .clk(clk),
    .resetn(resetn),
    .wrEn(pushNow),
    .wrAddr(sp_reg[`MIC_STACK_AW-1:0]),
    .wrData(cpuPc),
    .rdEn(popNow),
    .rdAddr(spMinus1[`MIC_STACK_AW-1:0]),
    .rdData(retPc)
  );

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      retValid <= 1'b0;
    end else begin
      retValid <= popNow;
    end
  end

  // vector loaded with the take pulse
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      irqTake <= 1'b0;
      vectorAddr <= '0;
    end else begin
      irqTake <= takeNow;
      if (takeNow) begin
        vectorAddr <= winVector;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  chk_take_needs_global: assert property (@(posedge clk) disable iff (!resetn)
    irqTake |-> $past(globalEn_reg) && !globalEn_reg)
    else $error("vector taken while global enable was low");

  chk_take_needs_enable: assert property (@(posedge clk) disable iff (!resetn)
    takeNow |-> $onehot(winner) && ((winner & ~srcEn_reg) == '0))
    else $error("vector taken with no enabled flag");

  chk_full_blocks_take: assert property (@(posedge clk) disable iff (!resetn)
    stackFull && !cpuPop |=> !irqTake && stackFull)
    else $error("request acknowledged with full stack");

  chk_vector_priority: assert property (@(posedge clk) disable iff (!resetn)
    takeNow && pending[`MIC_SRC_PIN] |=> vectorAddr == `MIC_VEC_PIN)
    else $error("pin request lost priority");

  chk_timer0_over_tb: assert property (@(posedge clk) disable iff (!resetn)
    takeNow && pending[`MIC_SRC_T0] && !pending[`MIC_SRC_PIN] |=> vectorAddr == `MIC_VEC_T0)
    else $error("timer0 request lost priority");

  chk_flag_auto_clear: assert property (@(posedge clk) disable iff (!resetn)
    takeNow && !apbWrite && ((winner & evtVec) == '0) |=> (srcFlag_reg & $past(winner)) == '0)
    else $error("serviced flag not cleared");

  chk_event_sets_flag: assert property (@(posedge clk) disable iff (!resetn)
    (timer0Evt && !wrPri) |=> srcFlag_reg[`MIC_SRC_T0])
    else $error("timer0 event did not set its flag");

  chk_wake_on_rise: assert property (@(posedge clk) disable iff (!resetn)
    (srcFlag_reg & ~$past(srcFlag_reg)) != '0 |-> wakeReq)
    else $error("flag rose without wake-up");

  chk_push_on_take: assert property (@(posedge clk) disable iff (!resetn)
    takeNow |=> sp_reg == $past(sp_reg) + 4'h1 ##1 1'b1)
    else $error("stack pointer did not advance on take");

  chk_reti_restores: assert property (@(posedge clk) disable iff (!resetn)
    popNow && cpuPopIsReti && !wrPri |=> retValid && globalEn_reg)
    else $error("return did not resume with global enable");
endmodule : mic_irq_controller
`default_nettype wire

//--- verification/mic_cpu_model.sv
// behavioural model of the core sequencer that drives the call and return handshake
`default_nettype none
`include "mic_regs.svh"
module mic_cpu_model
  import mic_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic irqTake,
  input wire mic_pc_t vectorAddr,
  input wire logic retValid,
  input wire mic_pc_t retPc,
  input wire logic callReq,
  input wire logic retReq,
  input wire logic retIsReti,
  output logic cpuIrqWindow,
  output mic_pc_t cpuPc,
  output logic cpuPush,
  output logic cpuPop,
  output logic cpuPopIsReti
);
  timeunit 1ns;
  timeprecision 1ps;
  // no boundary while a return is in flight: pc is not restored yet
  assign cpuIrqWindow = !(cpuPop || retValid || irqTake);
  ////////////////////////////////////////////////////////////////
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cpuPc <= 12'h100;
      cpuPush <= 1'b0;
      cpuPop <= 1'b0;
      cpuPopIsReti <= 1'b0;
    end else begin
      cpuPush <= callReq;
      cpuPop <= retReq;
      cpuPopIsReti <= retReq && retIsReti;
      if (irqTake) begin
        cpuPc <= vectorAddr + 12'h001;
      end else if (retValid) begin
        cpuPc <= retPc;
      end else if (cpuPush) begin
        cpuPc <= cpuPc + 12'h010;
      end
    end
  end
endmodule : mic_cpu_model
`default_nettype wire

//--- verification/tb.sv
// self-checking bench for the interrupt controller
`default_nettype none
`include "mic_regs.svh"
module tb
  import mic_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] q; logic e;} mic_row_t;
  logic clk, resetn, psel, penable, pwrite, pready, pslverr, intPin, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic t0Evt, tbEvt, t1Evt, cvEvt, callReq, retReq, retIsReti, win, push, pop, popReti;
  logic irqTake, retValid, stackFull, pinLevel, wakeReq;
  mic_pc_t cpuPc, vectorAddr, retPc, lastVec, lastRet;
  int n_fail, cmp_count, takeCnt, retCnt, wakeCnt, k0, w0;
  mic_pc_t vecs[5] = '{`MIC_VEC_PIN, `MIC_VEC_T0, `MIC_VEC_TB, `MIC_VEC_T1, `MIC_VEC_CONV};
  mic_row_t rows[8] = '{'{8'h00, 32'hffffffff, 32'h03, 1'b0}, '{8'h04, 32'h0000008e, 32'h0e, 1'b0},
    '{8'h08, 32'hffffffff, 32'h33, 1'b0}, '{8'h0c, 32'hffffffff, 32'h00, 1'b0},
    '{8'h10, 32'hffffffff, 32'h00, 1'b1}, '{8'h08, 32'h0, 32'h0, 1'b0},
    '{8'h04, 32'h0, 32'h0, 1'b0}, '{8'h00, 32'h0, 32'h0, 1'b0}};

  mic_irq_controller #(.HAS_CONV(1'b1)) dut_u (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .intPin(intPin), .timer0Evt(t0Evt), .timebaseEvt(tbEvt), .timer1Evt(t1Evt), .convEvt(cvEvt),
    .cpuIrqWindow(win), .cpuPc(cpuPc), .cpuPush(push), .cpuPop(pop), .cpuPopIsReti(popReti),
    .irqTake(irqTake), .vectorAddr(vectorAddr), .retValid(retValid), .retPc(retPc),
    .stackFull(stackFull), .pinLevel(pinLevel), .wakeReq(wakeReq));
  mic_cpu_model cpu_u (.clk(clk), .resetn(resetn), .irqTake(irqTake), .vectorAddr(vectorAddr),
    .retValid(retValid), .retPc(retPc), .callReq(callReq), .retReq(retReq), .retIsReti(retIsReti),
    .cpuIrqWindow(win), .cpuPc(cpuPc), .cpuPush(push), .cpuPop(pop), .cpuPopIsReti(popReti));

  ////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    if (irqTake === 1'b1) begin
      takeCnt++;
      lastVec = vectorAddr;
    end
    if (retValid === 1'b1) begin
      retCnt++;
      lastRet = retPc;
    end
    if (wakeReq === 1'b1) wakeCnt++;
  end
  initial begin
    #(20000 * 40);
    n_fail++;
    close_out();
  end

  ////////////////////////////////////////////////////////////////
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : close_out
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // ends with an idle edge so back-to-back calls never retoggle psel in one step
  // only the watchdog ends a wait for pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask : rdchk
  task automatic pulse(input logic [3:0] m);
    {cvEvt, t1Evt, tbEvt, t0Evt} <= m;
    @(posedge clk);
    {cvEvt, t1Evt, tbEvt, t0Evt} <= 4'h0;
  endtask : pulse
  task automatic waitCnt(input bit ret, input int tgt);
    int n;
    n = 0;
    while ((ret ? retCnt : takeCnt) < tgt && n < 40) begin
      @(posedge clk);
      n++;
    end
    if ((ret ? retCnt : takeCnt) < tgt) n_fail++;
  endtask : waitCnt
  task automatic popN(input int n, input logic reti);
    retReq <= 1'b1;
    retIsReti <= reti;
    repeat (n) @(posedge clk);
    retReq <= 1'b0;
  endtask : popN

  ////////////////////////////////////////////////////////////////
  initial begin
    {resetn, psel, penable, pwrite, intPin, callReq, retReq, retIsReti} = 8'h00;
    {cvEvt, t1Evt, tbEvt, t0Evt} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    {n_fail, cmp_count, takeCnt, retCnt, wakeCnt} = {5{32'sd0}};
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    repeat (4) @(posedge clk);
    for (int i = 0; i < 4; i++) rdchk(8'(i * 4), 32'h0);
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, rows[i].a, rows[i].d);
      chk({31'h0, err}, {31'h0, rows[i].e});
      rdchk(rows[i].a, rows[i].q);
    end
    apb(1'b1, 8'h04, 32'h2);
    for (int m = 0; m < 4; m++) begin
      apb(1'b1, 8'h00, 32'(m));
      intPin <= 1'b1;
      repeat (8) @(posedge clk);
      chk({31'h0, pinLevel}, 32'h1);
      rdchk(8'h0c, 32'h1);
      rdchk(8'h04, {27'h0, m[0], 4'h2});
      apb(1'b1, 8'h04, 32'h2);
      intPin <= 1'b0;
      repeat (8) @(posedge clk);
      chk({31'h0, pinLevel}, 32'h0);
      rdchk(8'h04, {27'h0, m[1], 4'h2});
      apb(1'b1, 8'h04, 32'h2);
    end
    w0 = wakeCnt;
    pulse(4'h1);
    repeat (3) @(posedge clk);
    chk(32'(wakeCnt - w0), 32'h1);
    rdchk(8'h04, 32'h42);
    pulse(4'h1);
    repeat (3) @(posedge clk);
    chk(32'(wakeCnt - w0), 32'h1);
    pulse(4'he);
    rdchk(8'h08, 32'h30);
    k0 = takeCnt;
    apb(1'b1, 8'h04, 32'h71);
    repeat (6) @(posedge clk);
    chk(32'(takeCnt - k0), 32'h0);
    apb(1'b1, 8'h04, 32'h7e);
    apb(1'b1, 8'h08, 32'h33);
    repeat (6) @(posedge clk);
    chk(32'(takeCnt - k0), 32'h0);
    apb(1'b1, 8'h04, 32'h7f);
    w0 = retCnt;
    for (int s = 0; s < 5; s++) begin
      waitCnt(1'b0, k0 + s + 1);
      chk(32'(lastVec), 32'(vecs[s]));
      if (s == 0) rdchk(8'h04, 32'h6e);
      if (s == 0) rdchk(8'h0c, 32'h10);
      popN(1, 1'b1);
      waitCnt(1'b1, w0 + s + 1);
      chk(32'(lastRet), 32'h100);
    end
    rdchk(8'h04, 32'h0f);
    rdchk(8'h08, 32'h03);
    callReq <= 1'b1;
    repeat (7) @(posedge clk);
    callReq <= 1'b0;
    k0 = takeCnt;
    pulse(4'h4);
    waitCnt(1'b0, k0 + 1);
    chk(32'(lastVec), 32'(`MIC_VEC_T1));
    rdchk(8'h0c, 32'h82);
    chk({31'h0, stackFull}, 32'h1);
    apb(1'b1, 8'h04, 32'h0f);
    pulse(4'h1);
    repeat (8) @(posedge clk);
    chk(32'(takeCnt - k0), 32'h1);
    w0 = retCnt;
    popN(1, 1'b0);
    waitCnt(1'b1, w0 + 1);
    chk(32'(lastRet), 32'h170);
    waitCnt(1'b0, k0 + 2);
    chk(32'(lastVec), 32'(`MIC_VEC_T0));
    popN(8, 1'b0);
    waitCnt(1'b1, w0 + 9);
    chk(32'(lastRet), 32'h100);
    rdchk(8'h0c, 32'h00);
    // mid-run reset with a flag pending: the take, return, wake and full outputs and the primary register must come back cleared
    pulse(4'h1);
    resetn <= 1'b0;
    @(posedge clk);
    chk({28'h0, irqTake, retValid, wakeReq, stackFull}, 32'h0);
    @(posedge clk);
    resetn <= 1'b1;
    rdchk(8'h04, 32'h00);
    close_out();
  end
endmodule : tb
`default_nettype wire
